//--- mscg_pkg.sv
/*
  package for the multi-source clock generator: register offsets, field
  positions, reset values, divider codes and operating mode enumeration.
  assumes nothing of its surroundings.
*/
package mscg_pkg;

  // register map, byte offsets on the plain register port
  localparam logic [3:0] MSCG_ADDR_CTRL1 = 4'h0;   // clock_gen_control_one
  localparam logic [3:0] MSCG_ADDR_CTRL2 = 4'h1;   // bus divider and oscillator control
  localparam logic [3:0] MSCG_ADDR_STAT = 4'h2;    // mode, lock and monitor status
  localparam logic [3:0] MSCG_ADDR_MODE = 4'h3;    // stop request and loop choice

  // field positions of control one
  localparam int MSCG_SRC_SEL_LSB = 6;
  localparam int MSCG_REF_DIV_LSB = 3;
  localparam int MSCG_REF_SEL_BIT = 2;
  localparam int MSCG_IR_OUT_EN_BIT = 1;
  localparam int MSCG_IRSTEN_BIT = 0;

  // field positions of control two
  localparam int MSCG_BUS_DIV_LSB = 6;
  localparam int MSCG_OSCEN_BIT = 2;
  localparam int MSCG_LP_BIT = 3;

  // field positions of the mode register
  localparam int MSCG_STOP_BIT = 0;
  localparam int MSCG_PLLS_BIT = 1;
  localparam int MSCG_CME_BIT = 2;

  // reset values
  localparam logic [7:0] MSCG_CTRL1_RST = 8'h04;   // loop source, div 1, internal ref
  localparam logic [7:0] MSCG_CTRL2_RST = 8'h40;   // bus divide by 2
  localparam logic [7:0] MSCG_MODE_RST = 8'h00;

  // clock source select codes
  localparam logic [1:0] MSCG_SRC_LOOP = 2'h0;
  localparam logic [1:0] MSCG_SRC_INT = 2'h1;
  localparam logic [1:0] MSCG_SRC_EXT = 2'h2;
  localparam logic [1:0] MSCG_SRC_RSVD = 2'h3;

  // reference divider code giving the largest ratio
  localparam logic [2:0] MSCG_REF_DIV_MAX = 3'h7;

  // divider counter width: 2^7 = 128 needs 7 bits
  localparam int MSCG_DIV_W = 7;

  // external clock monitor: cycles without an edge before failure
  localparam logic [7:0] MSCG_MON_LIMIT = 8'h40;
  // lock detector: reference divider ticks before lock
  localparam logic [7:0] MSCG_LOCK_LIMIT = 8'h20;

  // operating modes
  typedef enum logic [3:0] {
    MSCG_FLL_ENG_INT, MSCG_FLL_ENG_EXT, MSCG_FLL_BYP_INT, MSCG_FLL_BYP_EXT,
    MSCG_PLL_ENG_EXT, MSCG_PLL_BYP_EXT, MSCG_LP_BYP_INT, MSCG_LP_BYP_EXT, MSCG_STOP
  } mscg_mode_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mscg_req_t;

endpackage

//--- mscg_div.sv
/*
  power-of-two clock divider producing a one-cycle enable pulse and a
  divided square level. assumes a synchronous source enable on core_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module mscg_div
  import mscg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic src_en_i,        // one-cycle tick of the source
  input wire logic [2:0] shift_i,   // divide by 2^shift_i
  output logic tick_o,              // one pulse at each toggle of level_o
  output logic level_o              // divided square wave
);
  logic [MSCG_DIV_W-1:0] cnt_reg;
  logic [MSCG_DIV_W-1:0] cnt_next;
  logic [MSCG_DIV_W-1:0] last;
  logic level_reg;
  logic level_next;

  // terminal count is ratio minus one
  assign last = MSCG_DIV_W'((1 << shift_i) - 1);

  // next count and level
  always_comb begin
    cnt_next = cnt_reg;
    level_next = level_reg;
    if (src_en_i) begin
      if (cnt_reg >= last) begin
        cnt_next = '0;
        level_next = ~level_reg;
      end else begin
        cnt_next = cnt_reg + MSCG_DIV_W'(1);
      end
    end
  end

  // register the divider state
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      level_reg <= level_next;
    end
  end

  assign tick_o = src_en_i && (cnt_reg >= last);
  assign level_o = level_reg;
endmodule
`default_nettype wire

//--- mscg_top.sv
/*
  multi-source clock generator core: register file, reference select and
  divider, source mux, bus divider, debug clock, stop gating, lock detect
  and external clock monitor. assumes clock sources arrive as levels from
  on-chip oscillators and are synchronised here; the controlled oscillator
  is given as a level.
*/
// Chosen here: the address-and-strobe port and the register addresses.
// Summary of operation
// - source code 00 selects loop output
// - code 01 internal, 10 external reference
// - reserved code 11 acts like 00
// - reference divider codes 0..4 divide 1..16
// - reference divider code 7 divides by 128
// - reference select bit: internal set, external clear
// - internal ref output only when enable set
// - stop keeps internal ref under enable conditions
// - selected source divided by 1,2,4,8
// - debug clock is controlled oscillator halved
// - nine operating modes supported
// - block controls external crystal oscillator
// - all signals stay on chip
// - pll lock detector flags lock changes
// - external clock monitor requests reset on failure
// - fll reference chosen by reference select
// - bus divider codes, reset divide by two
`timescale 1ns/10ps
`default_nettype none
module mscg_top
  import mscg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] reg_addr_i,     // register address
  input wire logic [7:0] reg_wdata_i,    // write data
  input wire logic reg_wr_i,             // write strobe
  input wire logic reg_rd_i,             // read strobe
  output logic [7:0] reg_rdata_o,        // read data, cycle after strobe
  input wire logic int_ref_i,            // internal reference level
  input wire logic ext_ref_i,            // external reference level
  input wire logic digitally_controlled_oscillator_i, // controlled oscillator level
  input wire logic pll_vco_i,            // pll vco output level
  output logic osc_enable_o,             // external oscillator enable
  output logic internal_ref_clock_out_o, // gated internal reference
  output logic generator_output_clock_o, // divided system clock
  output logic debug_interface_clock_o,  // dco divided by two
  output logic ref_div_clock_o,          // divided reference to loops
  output logic lock_event_o,             // pulse on lock gained or lost
  output logic clock_fail_reset_o        // monitor reset request
);
  mscg_req_t req;                        // bundled register request
  logic [7:0] ctrl1_reg, ctrl1_next;     // clock_gen_control_one
  logic [7:0] ctrl2_reg, ctrl2_next;     // bus divider, oscillator bits
  logic [7:0] mode_reg, mode_next;       // stop and loop choice
  logic [7:0] rdata_reg, rdata_next;     // read data
  logic [3:0] sync1_reg, sync2_reg;      // two-stage synchronisers
  logic [3:0] prev_reg;                  // previous synchronised level
  logic [3:0] rise;                      // rising edge of each source
  logic [3:0] swing;                     // either edge of each source
  logic [1:0] src_sel;                   // clock source select field
  logic [2:0] ref_div;                   // reference divider code
  logic ref_sel, ir_out_en, irsten, stop_req, plls, cme;
  logic ref_tick, ref_lvl, loop_tick, src_tick, bus_lvl, dbg_lvl;
  mscg_mode_t opmode_reg, opmode_next;   // decoded mode
  mscg_mode_t pre_stop_reg, pre_stop_next;
  logic ir_run;
  logic [7:0] mon_reg, mon_next;         // cycles since external edge
  logic fail_reg, fail_next;
  logic [7:0] lockc_reg, lockc_next;     // lock stability counter
  logic lock_reg, lock_next;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // field extraction
  assign src_sel = ctrl1_reg[MSCG_SRC_SEL_LSB +: 2];
  assign ref_div = ctrl1_reg[MSCG_REF_DIV_LSB +: 3];
  assign ref_sel = ctrl1_reg[MSCG_REF_SEL_BIT];
  assign ir_out_en = ctrl1_reg[MSCG_IR_OUT_EN_BIT];
  assign irsten = ctrl1_reg[MSCG_IRSTEN_BIT];
  assign stop_req = mode_reg[MSCG_STOP_BIT];
  assign plls = mode_reg[MSCG_PLLS_BIT];
  assign cme = mode_reg[MSCG_CME_BIT];

  // synchronise the four source levels through two flops
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= {pll_vco_i, digitally_controlled_oscillator_i, ext_ref_i, int_ref_i};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  assign rise = sync2_reg & ~prev_reg;
  // both edges feed the ratio dividers so that code zero passes the source
  assign swing = sync2_reg ^ prev_reg;

  // register writes and read data
  always_comb begin
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    mode_next = mode_reg;
    rdata_next = '0;
    if (req.wr) begin
      if (req.addr == MSCG_ADDR_CTRL1) begin
        ctrl1_next = req.wdata;
      end else if (req.addr == MSCG_ADDR_CTRL2) begin
        ctrl2_next = req.wdata;
      end else if (req.addr == MSCG_ADDR_MODE) begin
        mode_next = req.wdata;
      end
    end
    if (req.rd) begin
      if (req.addr == MSCG_ADDR_CTRL1) begin
        rdata_next = ctrl1_reg;
      end else if (req.addr == MSCG_ADDR_CTRL2) begin
        rdata_next = ctrl2_reg;
      end else if (req.addr == MSCG_ADDR_STAT) begin
        rdata_next = {fail_reg, lock_reg, ir_run, 1'b0, 4'(opmode_reg)};
      end else if (req.addr == MSCG_ADDR_MODE) begin
        rdata_next = mode_reg;
      end
      // unmapped addresses read zero
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl1_reg <= MSCG_CTRL1_RST;
      ctrl2_reg <= MSCG_CTRL2_RST;
      mode_reg <= MSCG_MODE_RST;
      rdata_reg <= '0;
    end else begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      mode_reg <= mode_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata_o = rdata_reg;

  // reference chosen for divider and fll: internal when set
  // divide by 2^code, covering 1..16, 32, 64 and 128
  mscg_div u_ref_div (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .src_en_i(ref_sel ? swing[0] : swing[1]),
    .shift_i(ref_div),
    .tick_o(ref_tick),
    .level_o(ref_lvl)
  );

  // loop output is the controlled oscillator in fll modes, vco in pll modes
  assign loop_tick = plls ? swing[3] : swing[2];

  // source mux; reserved code falls back to loop
  always_comb begin
    case (src_sel)
      MSCG_SRC_INT: src_tick = swing[0];
      MSCG_SRC_EXT: src_tick = swing[1];
      default: src_tick = loop_tick;
    endcase
  end

  // bus divider by 1,2,4,8 on the chosen source
  mscg_div u_bus_div (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .src_en_i(src_tick),
    .shift_i({1'b0, ctrl2_reg[MSCG_BUS_DIV_LSB +: 2]}),
    .tick_o(),
    .level_o(bus_lvl)
  );

  // debug clock is the controlled oscillator halved in every mode
  mscg_div u_dbg_div (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .src_en_i(rise[2]),
    .shift_i(3'h0),
    .tick_o(),
    .level_o(dbg_lvl)
  );

  // mode decode from source, reference and low power bits
  always_comb begin
    pre_stop_next = pre_stop_reg;
    if (stop_req) begin
      opmode_next = MSCG_STOP;
    end else begin
      case (src_sel)
        MSCG_SRC_INT: opmode_next = ctrl2_reg[MSCG_LP_BIT] ? MSCG_LP_BYP_INT : MSCG_FLL_BYP_INT;
        MSCG_SRC_EXT: begin
          if (ctrl2_reg[MSCG_LP_BIT]) begin
            opmode_next = MSCG_LP_BYP_EXT;
          end else begin
            opmode_next = plls ? MSCG_PLL_BYP_EXT : MSCG_FLL_BYP_EXT;
          end
        end
        default: begin
          if (plls) begin
            opmode_next = MSCG_PLL_ENG_EXT;
          end else begin
            opmode_next = ref_sel ? MSCG_FLL_ENG_INT : MSCG_FLL_ENG_EXT;
          end
        end
      endcase
      pre_stop_next = opmode_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      opmode_reg <= MSCG_FLL_ENG_INT;
      pre_stop_reg <= MSCG_FLL_ENG_INT;
    end else begin
      opmode_reg <= opmode_next;
      pre_stop_reg <= pre_stop_next;
    end
  end

  // internal reference runs outside stop; in stop only if enabled and
  // either output enabled or entered from an internal-ref mode
  assign ir_run = (opmode_reg != MSCG_STOP) ||
                  (irsten && (ir_out_en || pre_stop_reg == MSCG_FLL_ENG_INT ||
                   pre_stop_reg == MSCG_FLL_BYP_INT || pre_stop_reg == MSCG_LP_BYP_INT));

  // external clock monitor and pll lock detector
  always_comb begin
    mon_next = mon_reg;
    fail_next = fail_reg;
    lockc_next = lockc_reg;
    lock_next = lock_reg;
    if (rise[1]) begin
      mon_next = '0;
    end else if (mon_reg != MSCG_MON_LIMIT) begin
      mon_next = mon_reg + 8'h01;
    end
    // failure only watched when monitor enabled and oscillator used
    fail_next = cme && ctrl2_reg[MSCG_OSCEN_BIT] && (mon_reg == MSCG_MON_LIMIT);
    // lock after reference ticks with pll selected; cleared when pll off or external reference stalled in a cycle without vco rise
    if (!plls || !rise[3] && (mon_reg == MSCG_MON_LIMIT)) begin
      lockc_next = '0;
      lock_next = 1'b0;
    end else if (ref_tick) begin
      if (lockc_reg == MSCG_LOCK_LIMIT) begin
        lock_next = 1'b1;
      end else begin
        lockc_next = lockc_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mon_reg <= '0;
      fail_reg <= 1'b0;
      lockc_reg <= '0;
      lock_reg <= 1'b0;
    end else begin
      mon_reg <= mon_next;
      fail_reg <= fail_next;
      lockc_reg <= lockc_next;
      lock_reg <= lock_next;
    end
  end

  // all outputs go to on-chip logic only
  assign osc_enable_o = ctrl2_reg[MSCG_OSCEN_BIT];
  assign internal_ref_clock_out_o = ir_out_en && ir_run && sync2_reg[0];
  assign generator_output_clock_o = bus_lvl;
  assign debug_interface_clock_o = dbg_lvl;
  assign ref_div_clock_o = ref_lvl;
  assign lock_event_o = lock_reg != lock_next;
  assign clock_fail_reset_o = fail_reg;

  // checks
  chk_src_int_sel: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (src_sel == MSCG_SRC_INT) |-> (src_tick == swing[0]))
    else $error("internal source not selected");
  chk_src_rsvd: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (src_sel == MSCG_SRC_RSVD) |-> (src_tick == loop_tick))
    else $error("reserved code not treated as loop");
  chk_src_loop: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (src_sel == MSCG_SRC_LOOP) |-> (src_tick == loop_tick))
    else $error("loop source not selected");
  chk_irclk_gate: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !ir_out_en |-> !internal_ref_clock_out_o)
    else $error("internal ref out active while disabled");
  chk_stop_gate: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (opmode_reg == MSCG_STOP && !irsten) |-> !ir_run)
    else $error("internal ref running in stop without enable");
  chk_dbg_half: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    rise[2] |=> (dbg_lvl != $past(dbg_lvl)))
    else $error("debug clock not oscillator halved");
  chk_reference_divider_max: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (ref_div == MSCG_REF_DIV_MAX && ref_tick) |-> (u_ref_div.cnt_reg == 7'h7f))
    else $error("reference divider not 128");
  chk_write_ctrl1: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == MSCG_ADDR_CTRL1) |=> (ctrl1_reg == $past(reg_wdata_i)))
    else $error("control one write lost");
  chk_fail_reset: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    clock_fail_reset_o |-> $past(cme))
    else $error("monitor reset without enable");
  cov_pll_eng: cover property (@(posedge core_clk_i) opmode_reg == MSCG_PLL_ENG_EXT);
  cov_stop_run: cover property (@(posedge core_clk_i) opmode_reg == MSCG_STOP && ir_run);
  cov_lock: cover property (@(posedge core_clk_i) lock_event_o);
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  self-checking bench for the multi-source clock generator: register
  reset values and access, source select, bus and reference dividers,
  debug clock, internal reference gating in run and stop, oscillator
  enable and the external clock monitor.
  assumes mscg_pkg and mscg_top are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import mscg_pkg::*;
;
  logic core_clk_i = 1'b0;       // 250 mhz core clock
  logic nrst_i = 1'b0;           // active low reset
  logic [3:0] addr = 4'h0;       // register address
  logic [7:0] wdata = 8'h00;     // write data
  logic wr = 1'b0;               // write strobe
  logic rd = 1'b0;               // read strobe
  logic int_ref = 1'b0;          // internal reference, period 8
  logic ext_ref = 1'b0;          // external reference, period 12
  logic osc_dig = 1'b0;          // controlled oscillator level, period 6
  logic vco = 1'b0;              // pll vco level, period 10
  logic ext_run = 1'b1;          // external oscillator running
  logic [7:0] rdata;
  logic osc_en, irclk, gen_clk, dbg_clk, ref_clk, lock_ev, fail;
  logic [7:0] mdl [4];           // expected register contents
  logic [7:0] st;                // status read back
  int cyc = 0;                   // cycle counter for sources and timeout
  int errors = 0;
  int samples_checked = 0;
  int seed;
  int p;

  mscg_top dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .int_ref_i(int_ref), .ext_ref_i(ext_ref), .pll_vco_i(vco),
    .digitally_controlled_oscillator_i(osc_dig),
    .osc_enable_o(osc_en), .internal_ref_clock_out_o(irclk),
    .generator_output_clock_o(gen_clk), .debug_interface_clock_o(dbg_clk),
    .ref_div_clock_o(ref_clk), .lock_event_o(lock_ev), .clock_fail_reset_o(fail)
  );

  // core clock, 4 ns period
  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  // source levels and hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    int_ref <= (cyc % 8) < 4;
    osc_dig <= (cyc % 6) < 3;
    vco <= (cyc % 10) < 5;
    if (ext_run) begin
      ext_ref <= (cyc % 12) < 6;
    end
    if (cyc == 40000) begin
      errors = errors + 1;
      give_verdict();
    end
  end

  // closing report
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // exact compare of a design value
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // register reset model
  task automatic mdl_reset();
    mdl[0] = MSCG_CTRL1_RST;
    mdl[1] = MSCG_CTRL2_RST;
    mdl[2] = 8'h00;
    mdl[3] = MSCG_MODE_RST;
  endtask

  // one-cycle write, model follows writable places only
  task automatic rw(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
    if (a < 4'h4 && a != MSCG_ADDR_STAT) begin
      mdl[a[1:0]] = d;
    end
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rget(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // read and compare with model, unmapped reads give zero
  task automatic rcheck(input logic [3:0] a);
    logic [7:0] v;
    rget(a, v);
    chk8("rdata", (a < 4'h4) ? mdl[a[1:0]] : 8'h00, v);
  endtask

  // pick an output clock for edge counting
  function automatic logic pick(input int s);
    case (s)
      0: pick = gen_clk;
      1: pick = ref_clk;
      2: pick = dbg_clk;
      default: pick = irclk;
    endcase
  endfunction

  // count toggles over a window, one toggle of slack for phase
  task automatic measure(input int s, input int win, input int e, input string nm);
    int tog;
    logic prv;
    logic cur;
    tog = 0;
    repeat (24) @(posedge core_clk_i);
    #1;
    prv = pick(s);
    repeat (win) begin
      @(posedge core_clk_i);
      #1;
      cur = pick(s);
      if (cur !== prv) tog++;
      prv = cur;
    end
    samples_checked++;
    if (tog < e - ((e > 0) ? 1 : 0) || tog > e + ((e > 0) ? 1 : 0)) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, tog);
    end
  endtask

  // main sequence
  initial begin
    seed = 16439;
    mdl_reset();
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rcheck(MSCG_ADDR_CTRL1);
    rcheck(MSCG_ADDR_CTRL2);
    rcheck(MSCG_ADDR_MODE);
    rw(4'h9, 8'hff);
    rcheck(4'h9);
    repeat (4) begin
      rw(MSCG_ADDR_CTRL1, 8'($random(seed)));
      rcheck(MSCG_ADDR_CTRL1);
    end
    // every source code against every bus divider code
    for (int c = 0; c < 4; c++) begin
      for (int b = 0; b < 4; b++) begin
        rw(MSCG_ADDR_CTRL2, 8'(b << 6));
        rw(MSCG_ADDR_CTRL1, 8'(c << 6) | 8'h04);
        p = (c == 1) ? 8 : (c == 2) ? 12 : 6;
        measure(0, p * 4 * (1 << b), 8, "gen_clk");
      end
    end
    rw(MSCG_ADDR_MODE, 8'h02);
    rw(MSCG_ADDR_CTRL1, 8'h00);
    rw(MSCG_ADDR_CTRL2, 8'h00);
    measure(0, 40, 8, "gen_clk_pll");
    rw(MSCG_ADDR_MODE, 8'h00);
    // every reference divider code, alternating reference
    for (int r = 0; r < 8; r++) begin
      rw(MSCG_ADDR_CTRL1, 8'(r << 3) | ((r % 2) ? 8'h04 : 8'h00));
      measure(1, ((r % 2) ? 8 : 12) * 4 * (1 << r), 8, "ref_div");
    end
    measure(2, 24, 4, "debug_clk");
    // internal reference gating in run and stop
    rw(MSCG_ADDR_CTRL1, 8'h00);
    measure(3, 32, 0, "irclk_off");
    rw(MSCG_ADDR_CTRL1, 8'h02);
    measure(3, 32, 8, "irclk_on");
    rw(MSCG_ADDR_MODE, 8'h01);
    measure(3, 32, 0, "irclk_stop");
    rw(MSCG_ADDR_CTRL1, 8'h03);
    measure(3, 32, 8, "irclk_stop_keep");
    rget(MSCG_ADDR_STAT, st);
    chk8("stat_stop", 8'h28, st);
    // stop entered from an internal-ref mode keeps it without output enable
    rw(MSCG_ADDR_MODE, 8'h00);
    rw(MSCG_ADDR_CTRL1, 8'h05);
    rw(MSCG_ADDR_MODE, 8'h01);
    rget(MSCG_ADDR_STAT, st);
    chk8("stat_stop_int", 8'h28, st);
    rw(MSCG_ADDR_MODE, 8'h00);
    rw(MSCG_ADDR_CTRL1, 8'h01);
    rw(MSCG_ADDR_MODE, 8'h01);
    rget(MSCG_ADDR_STAT, st);
    chk8("stat_stop_ext", 8'h08, st);
    // pll engaged external on the oscillator, reference divided by 16
    rw(MSCG_ADDR_CTRL2, 8'h04);
    rw(MSCG_ADDR_CTRL1, 8'h20);
    rw(MSCG_ADDR_MODE, 8'h02);
    p = 0;
    repeat (5000) begin
      @(posedge core_clk_i);
      #1;
      if (lock_ev === 1'b1) p++;
    end
    chk8("lock_events", 8'h01, 8'(p));
    rget(MSCG_ADDR_STAT, st);
    chk8("stat_pll", 8'h64, st);
    rw(MSCG_ADDR_MODE, 8'h00);
    #1;
    chk8("lock_lost", 8'h01, {7'h0, lock_ev});
    rw(MSCG_ADDR_MODE, 8'h00);
    rcheck(MSCG_ADDR_CTRL1);
    // oscillator enable follows its bit
    rw(MSCG_ADDR_CTRL2, 8'h04);
    #1;
    chk8("osc_en", 8'h01, {7'h0, osc_en});
    rw(MSCG_ADDR_CTRL2, 8'h00);
    #1;
    chk8("osc_en", 8'h00, {7'h0, osc_en});
    // monitor quiet while the clock runs, then trips
    rw(MSCG_ADDR_CTRL2, 8'h04);
    rw(MSCG_ADDR_MODE, 8'h04);
    repeat (200) @(posedge core_clk_i);
    #1;
    chk8("fail", 8'h00, {7'h0, fail});
    @(posedge core_clk_i);
    ext_run <= 1'b0;
    repeat (150) @(posedge core_clk_i);
    #1;
    chk8("fail", 8'h01, {7'h0, fail});
    rget(MSCG_ADDR_STAT, st);
    chk8("stat_fail", 8'h01, {7'h0, st[7]});
    // second reset in mid-run clears fail and returns both control registers to reset values
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    ext_run <= 1'b1;
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    mdl_reset();
    #1;
    chk8("fail", 8'h00, {7'h0, fail});
    rcheck(MSCG_ADDR_CTRL1);
    rcheck(MSCG_ADDR_CTRL2);
    give_verdict();
  end
endmodule
`default_nettype wire
